// ### include/chmon_pkg.sv
// chmon_pkg: constants, register map and carrier types of the charger monitor
// converter control block.
// assumes a 40 MHz system clock and word-wide register accesses by command code.
`default_nettype none
package chmon_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned CONV_TIME_MS = 10; // one full conversion set
	localparam int unsigned PERIOD_TIME_MS = 1000; // continuous repeat period
	localparam int unsigned CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
	localparam int unsigned PERIOD_CYCLES = CLK_HZ / 1000 * PERIOD_TIME_MS;
	localparam int unsigned NUM_CHAN = 8;
	// register command codes
	localparam logic [7:0] ADDR_STATE_FLAGS = 8'h20;
	localparam logic [7:0] ADDR_THROTTLE_PROFILE = 8'h34;
	localparam logic [7:0] ADDR_CONV_OPTION = 8'h35;
	// reset values
	localparam logic [15:0] RST_THROTTLE_PROFILE = 16'h8120;
	localparam logic [15:0] RST_CONV_OPTION = 16'h2000;
	// converter option field positions
	localparam int unsigned POS_REPEAT = 15;
	localparam int unsigned POS_START = 14;
	localparam int unsigned POS_RANGE = 13;
	localparam int unsigned POS_RESV_HI = 12;
	localparam int unsigned POS_RESV_LO = 8;
	// throttle profile field position
	localparam int unsigned POS_ADAPTER_LOSS = 0;
	// state flags field position written by the host
	localparam int unsigned POS_SYS_OVP = 4;
	// channel order in a conversion set
	typedef enum logic [2:0] {
		CH_BAT_VOLT = 3'h0,
		CH_SYS_VOLT = 3'h1,
		CH_CHG_CUR = 3'h2,
		CH_DCHG_CUR = 3'h3,
		CH_IN_CUR = 3'h4,
		CH_SYS_PWR = 3'h5,
		CH_BUS_VOLT = 3'h6,
		CH_CMP_IN = 3'h7
	} chmon_chan_type;
	// sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h0,
		SEQ_CONV = 2'h1,
		SEQ_WAIT = 2'h2
	} chmon_seq_type;
	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} chmon_regreq_type;
	// fault events from charger logic, one-cycle pulses or levels
	typedef struct packed {
		logic ac_overvolt;
		logic bat_overcur;
		logic ac_overcur;
		logic latch_off;
		logic otg_overvolt;
		logic otg_undercur;
	} chmon_fault_type;
	// live charger status shown in the high byte of the state flags
	typedef struct packed {
		logic input_optimizer_done;
		logic in_volt_regulation;
		logic in_cur_regulation;
		logic in_fast_charge;
		logic in_pre_charge;
		logic in_otg;
	} chmon_live_type;
endpackage
`default_nettype wire

// ### hw/chmon_tick.sv
// chmon_tick: free counter that pulses once every LIMIT cycles while run is high.
// assumes run is a registered level from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module chmon_tick #(
	parameter int unsigned LIMIT = 50000
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic run,
	output logic done
);
	localparam int unsigned W = (LIMIT > 1) ? $clog2(LIMIT) : 1;
	localparam logic [W-1:0] LAST = W'(LIMIT - 1);
	typedef struct packed {
		logic [W-1:0] cnt;
	} chmon_tick_state_type;
	chmon_tick_state_type st_r;
	chmon_tick_state_type st_nxt;

	// counter restarts whenever run drops
	always_comb
	begin
		st_nxt = st_r;
		if (!run || st_r.cnt == LAST)
			st_nxt.cnt = '0;
		else
			st_nxt.cnt = st_r.cnt + W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	assign done = run && (st_r.cnt == LAST);
endmodule // chmon_tick
`default_nettype wire

// ### hw/chmon_ctrl.sv
// chmon_ctrl: monitor converter option register, conversion sequencer,
// throttle profile bit and charger state flags.
// assumes register requests arrive decoded from the host port, one per cycle,
// on the system clock; adapter and overvoltage levels arrive from pins.
// timing counts are parameters so a bench can shrink a set to a few cycles.
// Operation
// [R1] channel updates follow battery volt, system volt, charge, discharge, input, power, bus, comparator.
// [R2] the converter stays idle while low power mode is active.
// [R3] asking for conversion on battery only takes the device out of low power mode.
// [R4] one full conversion set takes ten milliseconds.
// [R5] in one-shot mode one set of updates follows each start.
// [R6] in continuous mode a full set of updates repeats every second.
// [R7] the host writes one to the start bit and the device clears it after a one-shot set.
// [R8] bit 13 selects the input range, zero low and one high, high after reset.
// [R9] the host should pick the low range for low input voltage or a single cell.
// [R10] eight channel enable bits, all off after reset, switch channels on.
// [R11] bits 12 to 8 of the option register are reserved, writable, zero after reset.
// [R12] with the adapter loss bit set, the throttle output goes low after adapter removal.
// [R13] the host keeps bit 15 of the first charge option clear to get the throttle pulse.
// [R14] fault flags in the low byte of the state flags stay set until the host reads them.
// [R15] system overvoltage sets a flag and stops the power stage until the host writes it to zero; the code also clears it on adapter removal.
// [R16] only enabled channels are converted and disabled result fields stay untouched.
`timescale 1ns/1ps
`default_nettype none
module chmon_ctrl
	import chmon_pkg::*;
#(
	parameter int unsigned CONV_CYC = chmon_pkg::CONV_CYCLES,
	parameter int unsigned PERIOD_CYC = chmon_pkg::PERIOD_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire chmon_pkg::chmon_regreq_type req,
	output logic [15:0] rdata,
	input wire logic adapter_present_pin,
	input wire logic sys_overvolt_pin,
	input wire logic low_power_request,
	input wire chmon_pkg::chmon_fault_type fault_event,
	input wire chmon_pkg::chmon_live_type live_status,
	output logic channel_update,
	output logic [2:0] channel_index,
	output logic conv_busy,
	output logic input_range_select,
	output logic low_power_mode,
	output logic converter_disable,
	output logic processor_throttle_n
);
	import chmon_pkg::*;

	localparam int unsigned SLOT_CYC = CONV_CYC / NUM_CHAN;

	// whole block state, registered as one word
	typedef struct packed {
		// sequencer position
		chmon_seq_type seq;
		logic [2:0] chan;
		// converter option register fields
		logic conversion_repeat_select;
		logic start;
		logic input_range_select;
		logic [4:0] resv;
		logic [7:0] chan_on;
		// throttle profile word and status flags
		logic [15:0] profile;
		chmon_fault_type faults;
		logic system_overvoltage_flag;
		// pin synchronisers and edge history
		logic adapt_s1;
		logic adapt_s2;
		logic adapt_d;
		logic ovp_s1;
		logic ovp_s2;
		// registered outputs
		logic removal;
		logic lp;
		logic upd;
		logic [2:0] upd_chan;
		logic [15:0] rdata;
	} chmon_state_type;

	chmon_state_type st_r;
	chmon_state_type st_nxt;
	// timer strobes
	logic slot_done;
	logic period_done;
	// decoded requests
	logic wr_opt;
	logic wr_prof;
	logic wr_flags;
	logic rd_flags;
	// adapter and low power levels
	logic adapter_fall;
	logic battery_only;
	logic lp_active;
	// register read views
	logic [15:0] flags_view;
	logic [15:0] opt_view;

	// slot timer paces one channel per eighth of a set
	chmon_tick #(
		.LIMIT(SLOT_CYC)
	) u_slot (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.run(st_r.seq == SEQ_CONV),
		.done(slot_done)
	);

	// period timer spaces continuous sets from set start to set start
	chmon_tick #(
		.LIMIT(PERIOD_CYC)
	) u_period (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.run(st_r.seq != SEQ_IDLE && st_r.conversion_repeat_select),
		.done(period_done)
	);

	// request decode, one command per cycle
	assign wr_opt = req.wr && req.addr == ADDR_CONV_OPTION;
	assign wr_prof = req.wr && req.addr == ADDR_THROTTLE_PROFILE;
	assign wr_flags = req.wr && req.addr == ADDR_STATE_FLAGS;
	assign rd_flags = req.rd && req.addr == ADDR_STATE_FLAGS;

	// adapter loss edge and battery-only level
	assign adapter_fall = st_r.adapt_d && !st_r.adapt_s2;
	assign battery_only = !st_r.adapt_s2;

	// [R3] battery-only conversion exit
	assign lp_active = low_power_request && !(st_r.start && battery_only);

	// state flags view: live status high, latched faults low
	assign flags_view = {
		st_r.adapt_s2, // input present
		live_status.input_optimizer_done,
		1'b0, // reserved
		live_status.in_volt_regulation,
		live_status.in_cur_regulation,
		live_status.in_fast_charge,
		live_status.in_pre_charge,
		live_status.in_otg,
		st_r.faults.ac_overvolt,
		st_r.faults.bat_overcur,
		st_r.faults.ac_overcur,
		st_r.system_overvoltage_flag,
		1'b0, // reserved
		st_r.faults.latch_off,
		st_r.faults.otg_overvolt,
		st_r.faults.otg_undercur
	};

	// option register view, field by field
	assign opt_view = {
		st_r.conversion_repeat_select,
		st_r.start,
		st_r.input_range_select,
		st_r.resv,
		st_r.chan_on
	};

	// next state of registers, flags and sequencer
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.upd = 1'b0;
		// pin synchronisers
		st_nxt.adapt_s1 = adapter_present_pin;
		st_nxt.adapt_s2 = st_r.adapt_s1;
		st_nxt.adapt_d = st_r.adapt_s2;
		st_nxt.ovp_s1 = sys_overvolt_pin;
		st_nxt.ovp_s2 = st_r.ovp_s1;
		st_nxt.lp = lp_active;

		// option register write
		if (wr_opt)
		begin
			st_nxt.conversion_repeat_select = req.wdata[POS_REPEAT];
			// [R7] host start write
			st_nxt.start = req.wdata[POS_START];
			// [R8] range select
			st_nxt.input_range_select = req.wdata[POS_RANGE];
			// [R11] reserved read/write
			st_nxt.resv = req.wdata[POS_RESV_HI:POS_RESV_LO];
			// [R10] channel enables
			st_nxt.chan_on = req.wdata[7:0];
		end

		// [R12] profile word, only the adapter loss bit acts
		if (wr_prof)
			st_nxt.profile = req.wdata;

		// [R14] faults held until read
		st_nxt.faults = (st_r.faults & ~{$bits(chmon_fault_type){rd_flags}}) | fault_event;

		// [R15] overvoltage latch, host write of zero clears
		if ((wr_flags && !req.wdata[POS_SYS_OVP]) || adapter_fall)
			st_nxt.system_overvoltage_flag = 1'b0;
		if (st_r.ovp_s2)
			st_nxt.system_overvoltage_flag = 1'b1;

		// [R12] adapter removal latch
		if (st_r.adapt_s2 || !st_r.profile[POS_ADAPTER_LOSS])
			st_nxt.removal = 1'b0;
		else if (adapter_fall)
			st_nxt.removal = 1'b1;

		// read data, unmapped reads give zero
		if (req.rd)
		begin
			unique case (req.addr)
				ADDR_STATE_FLAGS: st_nxt.rdata = flags_view;
				ADDR_THROTTLE_PROFILE: st_nxt.rdata = st_r.profile;
				ADDR_CONV_OPTION: st_nxt.rdata = opt_view;
				default: st_nxt.rdata = 16'h0000;
			endcase
		end

		// sequencer, one channel slot at a time
		unique case (st_r.seq)
			SEQ_IDLE:
			begin
				st_nxt.chan = CH_BAT_VOLT;
				// [R2] idle in low power
				if (st_r.start && !lp_active)
					st_nxt.seq = SEQ_CONV;
			end

			SEQ_CONV:
			begin
				// abort on low power or a cleared start
				if (lp_active || !st_nxt.start)
					st_nxt.seq = SEQ_IDLE;
				// [R4] eight slots make one set
				else if (slot_done)
				begin
					// [R16] enabled channels only
					st_nxt.upd = st_r.chan_on[st_r.chan];
					st_nxt.upd_chan = st_r.chan;
					// [R1] fixed channel order
					st_nxt.chan = st_r.chan + 3'h1;
					if (st_r.chan == CH_CMP_IN)
					begin
						if (st_r.conversion_repeat_select)
							st_nxt.seq = SEQ_WAIT;
						else
						begin
							// [R5] one-shot ends, start self-clears
							st_nxt.seq = SEQ_IDLE;
							if (!(wr_opt && req.wdata[POS_START]))
								st_nxt.start = 1'b0;
						end
					end
				end
			end

			SEQ_WAIT:
			begin
				st_nxt.chan = CH_BAT_VOLT;
				// leave on abort or when repeat is dropped
				if (lp_active || !st_nxt.start || !st_r.conversion_repeat_select)
					st_nxt.seq = SEQ_IDLE;
				// [R6] repeat every period
				else if (period_done)
					st_nxt.seq = SEQ_CONV;
			end

			// unused state code falls back to idle
			default:
				st_nxt.seq = SEQ_IDLE;
		endcase
	end

	// state register with clock enable
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			// clear all, then the non-zero reset fields
			st_r <= '0;
			st_r.seq <= SEQ_IDLE;
			st_r.input_range_select <= RST_CONV_OPTION[POS_RANGE];
			st_r.profile <= RST_THROTTLE_PROFILE;
		end
		else if (ce)
			st_r <= st_nxt;
	end

	// read data and channel update strobe
	assign rdata = st_r.rdata;
	assign channel_update = st_r.upd;
	assign channel_index = st_r.upd_chan;

	// converter activity and input range
	assign conv_busy = st_r.seq == SEQ_CONV;
	assign input_range_select = st_r.input_range_select;

	// power state and protection
	assign low_power_mode = st_r.lp;
	assign converter_disable = st_r.system_overvoltage_flag;

	// [R12] throttle low after removal
	assign processor_throttle_n = !st_r.removal;
endmodule // chmon_ctrl
`default_nettype wire

// ### sim/chmon_chk.sv
// chmon_chk: port-level checks of the monitor converter control block.
// assumes one clock and the synchronous reset of chmon_ctrl.
`timescale 1ns/1ps
`default_nettype none
module chmon_chk #(
	parameter int unsigned CONV_CYC = 400000,
	parameter int unsigned PERIOD_CYC = 40000000
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire chmon_pkg::chmon_regreq_type req,
	input wire logic adapter_present_pin,
	input wire logic sys_overvolt_pin,
	input wire logic channel_update,
	input wire logic [2:0] channel_index,
	input wire logic conv_busy,
	input wire logic input_range_select,
	input wire logic low_power_mode,
	input wire logic converter_disable,
	input wire logic processor_throttle_n
);
	import chmon_pkg::*;
	int unsigned busy_cnt_r;
	logic [2:0] last_idx_r;
	logic seen_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// busy length and last channel seen in this set
	always_ff @(posedge clk)
	begin
		busy_cnt_r <= conv_busy ? busy_cnt_r + 32'h1 : 32'h0;
		if (srst || (conv_busy && busy_cnt_r == 32'h0))
			seen_r <= 1'b0;
		else if (channel_update)
			seen_r <= 1'b1;
		if (channel_update)
			last_idx_r <= channel_index;
	end
	chk_update_in_set: assert property (channel_update |-> $past(conv_busy))
		else $error("channel update outside a set");
	chk_index_rises: assert property (channel_update && seen_r |-> channel_index > last_idx_r)
		else $error("channel order broken");
	chk_lp_blocks: assert property (low_power_mode && $past(low_power_mode) |-> !conv_busy)
		else $error("converting in low power");
	chk_set_span: assert property ($fell(conv_busy) && !low_power_mode && !$past(req.wr)
		&& !$past(req.wr, 2) |-> busy_cnt_r + 1 >= CONV_CYC && busy_cnt_r <= CONV_CYC + 1)
		else $error("set length wrong");
	chk_range_follows: assert property (ce && req.wr && req.addr == ADDR_CONV_OPTION
		|=> input_range_select == $past(req.wdata[13]))
		else $error("range bit not taken");
	chk_ovp_sets: assert property (sys_overvolt_pin [*4] |-> converter_disable)
		else $error("overvoltage flag late");
	chk_ovp_holds: assert property (converter_disable && sys_overvolt_pin
		&& $past(sys_overvolt_pin) && $past(sys_overvolt_pin, 2) |=> converter_disable)
		else $error("overvoltage flag dropped");
	chk_thr_release: assert property (adapter_present_pin [*6] |-> processor_throttle_n)
		else $error("throttle low with adapter");
	cover property ($fell(conv_busy));
	cover property (!processor_throttle_n);
	cover property (converter_disable);
endmodule // chmon_chk
bind chmon_ctrl chmon_chk #(.CONV_CYC(CONV_CYC), .PERIOD_CYC(PERIOD_CYC)) chmon_chk_inst (
	.clk(clk), .srst(srst), .ce(ce), .req(req), .adapter_present_pin(adapter_present_pin),
	.sys_overvolt_pin(sys_overvolt_pin), .channel_update(channel_update),
	.channel_index(channel_index), .conv_busy(conv_busy),
	.input_range_select(input_range_select), .low_power_mode(low_power_mode),
	.converter_disable(converter_disable), .processor_throttle_n(processor_throttle_n));
`default_nettype wire

// ### sim/chmon_host.sv
// chmon_host: register host model issuing one word request at a time.
// assumes rdata is registered and valid one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module chmon_host (
	input wire logic clk,
	input wire logic [15:0] rdata,
	output var chmon_pkg::chmon_regreq_type req
);
	import chmon_pkg::*;
	initial req = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] v);
		@(posedge clk) req <= '{wr: w, rd: !w, addr: a, wdata: v};
		@(posedge clk) req <= '0;
	endtask
	// read strobe, then take the word one cycle later
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		xfer(1'b0, a, 16'h0000);
		@(posedge clk);
		#1 v = rdata;
	endtask
endmodule // chmon_host
`default_nettype wire

// ### sim/tb_top.sv
// tb_top: self-checking bench for the monitor converter control block.
// assumes the host model carries all register traffic.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import chmon_pkg::*;
	localparam int CC = 80;
	localparam int PC = 400;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic adp = 1'b1;
	logic ovp = 1'b0;
	logic lp = 1'b0;
	chmon_fault_type flt = '0;
	chmon_live_type live = '0;
	chmon_regreq_type req;
	logic [15:0] rdata;
	logic upd_p;
	logic [2:0] idx;
	logic busy;
	logic rng;
	logic lpm;
	logic dis;
	logic thr_n;
	int upd = 0;
	int fail_count = 0;
	int compares = 0;
	chmon_ctrl #(.CONV_CYC(CC), .PERIOD_CYC(PC)) chmon_ctrl_inst (
		.clk(clk), .srst(srst), .ce(ce), .req(req), .rdata(rdata),
		.adapter_present_pin(adp), .sys_overvolt_pin(ovp), .low_power_request(lp),
		.fault_event(flt), .live_status(live), .channel_update(upd_p), .channel_index(idx),
		.conv_busy(busy), .input_range_select(rng), .low_power_mode(lpm),
		.converter_disable(dis), .processor_throttle_n(thr_n));
	chmon_host chmon_host_inst (.clk(clk), .rdata(rdata), .req(req));
	always #12.5 clk = ~clk;
	// count channel update pulses
	always @(posedge clk)
		if (upd_p === 1'b1)
			upd++;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		chmon_host_inst.rd(a, v);
		check(v, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		chmon_host_inst.xfer(1'b1, a, v);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic end_sim;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rchk(ADDR_CONV_OPTION, 16'h2000);
		check(16'(rng), 16'h0001);
		rchk(ADDR_THROTTLE_PROFILE, 16'h8120);
		rchk(8'h21, 16'h0000);
		upd = 0;
		wr(ADDR_CONV_OPTION, 16'h5F81);
		cyc(CC / 2);
		check(16'(busy), 16'h0001);
		cyc(CC / 2 + 40);
		check(16'(busy), 16'h0000);
		check(16'(upd), 16'h0002);
		check(16'(idx), 16'h0007);
		check(16'(rng), 16'h0000);
		rchk(ADDR_CONV_OPTION, 16'h1F81);
		upd = 0;
		wr(ADDR_CONV_OPTION, 16'hC0FF);
		cyc(2 * PC + CC + 20);
		check(16'(upd), 16'd24);
		rchk(ADDR_CONV_OPTION, 16'hC0FF);
		wr(ADDR_CONV_OPTION, 16'h0000);
		@(posedge clk) lp <= 1'b1;
		cyc(4);
		upd = 0;
		wr(ADDR_CONV_OPTION, 16'h40FF);
		cyc(CC + 20);
		check(16'(upd), 16'h0000);
		check(16'(lpm), 16'h0001);
		@(posedge clk) adp <= 1'b0;
		cyc(CC / 2);
		check(16'(lpm), 16'h0000);
		cyc(CC / 2 + 40);
		check(16'(upd), 16'h0008);
		check(16'(thr_n), 16'h0001);
		@(posedge clk) lp <= 1'b0;
		@(posedge clk) adp <= 1'b1;
		wr(ADDR_THROTTLE_PROFILE, 16'h8121);
		@(posedge clk) adp <= 1'b0;
		cyc(8);
		check(16'(thr_n), 16'h0000);
		@(posedge clk) adp <= 1'b1;
		cyc(8);
		check(16'(thr_n), 16'h0001);
		@(posedge clk) live <= '1;
		@(posedge clk) flt <= '1;
		@(posedge clk) flt <= '0;
		rchk(ADDR_STATE_FLAGS, 16'hDFE7);
		rchk(ADDR_STATE_FLAGS, 16'hDF00);
		@(posedge clk) ovp <= 1'b1;
		cyc(6);
		check(16'(dis), 16'h0001);
		@(posedge clk) ovp <= 1'b0;
		cyc(6);
		check(16'(dis), 16'h0001);
		wr(ADDR_STATE_FLAGS, 16'h0000);
		cyc(2);
		check(16'(dis), 16'h0000);
		@(posedge clk) ce <= 1'b0;
		wr(ADDR_CONV_OPTION, 16'h2000);
		@(posedge clk) ce <= 1'b1;
		rchk(ADDR_CONV_OPTION, 16'h00FF);
		end_sim();
	end
	// watchdog against a hang
	initial
	begin
		cyc(20000);
		fail_count++;
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
